/* File: rtl/lmcd_map.svh */
// Constants for the motion command decoder: frame codes, field positions and reset values.
`ifndef LMCD_MAP_SVH
`define LMCD_MAP_SVH

// ****************************************************************
// Frame identifiers and lengths
// ****************************************************************
`define LMCD_SLEEP_ID 6'h3c
`define LMCD_MOVE_LEN 4'h4
`define LMCD_CMD_LEN 4'h2
`define LMCD_SLEEP_LEN 4'h8
`define LMCD_ID_TYPE_BIT 5

// ****************************************************************
// Command opcodes and fixed bytes
// ****************************************************************
`define LMCD_OP_STOP 7'h0f
`define LMCD_OP_OBSERVE 7'h1f
`define LMCD_SLEEP_FIRST 8'h00
`define LMCD_SLEEP_FILL 8'hff
`define LMCD_FALLBACK_NONE 11'h400

// ****************************************************************
// Field positions
// ****************************************************************
`define LMCD_CMD_FLAG_BIT 7
`define LMCD_BROAD_BIT 7
`define LMCD_HI_NIB 7:4
`define LMCD_LO_NIB 3:0

// ****************************************************************
// Reset values
// ****************************************************************
`define LMCD_GOAL_RST 16'h0000
`define LMCD_NIB_RST 4'h0

`endif

/* File: rtl/lmcd_pkg.sv */
// Types shared by the motion command decoder and its surroundings.
package lmcd_pkg;

	// Received frame as handed over by the data-link layer.
	typedef struct packed {
		logic [7:0] ident;
		logic [7:0][7:0] data;
		logic [3:0] len;
		logic cksum_ok;
	} lmcd_frame_t;

	// Motion parameters loaded by a move command.
	typedef struct packed {
		logic [3:0] vmax;
		logic [3:0] vmin;
		logic [3:0] stall_threshold;
		logic [3:0] ramp_rate;
	} lmcd_params_t;

	// Command decoder state.
	typedef enum logic [1:0] {
		LMCD_RUN,
		LMCD_STOPPING,
		LMCD_ASLEEP
	} lmcd_state_t;

endpackage : lmcd_pkg

/* File: rtl/lmcd_decoder.sv */
// Motion command decoder: move, sleep, decelerating stop and back-EMF observation.
`timescale 1ns/100ps
`include "lmcd_map.svh"

module lmcd_decoder (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// Received frames from the data-link layer.
	input wire logic frame_valid_i,
	input wire lmcd_pkg::lmcd_frame_t frame_i,
	// Node configuration.
	input wire logic [6:0] node_address_i,
	input wire logic [5:0] move_ident_i,
	input wire logic [5:0] cmd_ident_i,
	// Motion controller status.
	input wire logic motion_busy_i,
	input wire logic two_stage_motion_i,
	input wire logic [15:0] current_position_i,
	input wire logic [10:0] fallback_position_i,
	input wire logic wake_i,
	// Asynchronous pins and analog levels.
	input wire logic thermal_shutdown_i,
	input wire logic end_stop_pin_i,
	input wire logic bemf_integrator_i,
	// Motion controller commands.
	output logic [15:0] goal_position_o,
	output lmcd_pkg::lmcd_params_t params_o,
	output logic move_start_o,
	output logic decel_stop_o,
	output logic sleep_o,
	output logic cmd_reject_o,
	// End-stop pin drive and sampled level.
	output logic end_stop_pin_o,
	output logic end_stop_pin_oe_o,
	output logic end_stop_level_o
);

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Computes the two protected identifier parity bits.
	function automatic logic [1:0] lmcd_parity(input logic [5:0] id);
		logic p0;
		logic p1;
		p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
		p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
		return {p1, p0};
	endfunction : lmcd_parity

	// True when a broadcast or address-matched command is meant for this node.
	function automatic logic lmcd_for_us(input logic [7:0] b, input logic [6:0] addr);
		return (b[`LMCD_BROAD_BIT] == 1'b0) || (b[6:0] == addr);
	endfunction : lmcd_for_us

	// True when a two-byte command frame carries the given opcode for this node.
	function automatic logic lmcd_cmd_hit(input lmcd_pkg::lmcd_frame_t f,
		input logic [5:0] id, input logic [6:0] addr, input logic [6:0] op);
		return (f.ident[5:0] == id)
			&& (f.len == `LMCD_CMD_LEN)
			&& (f.data[0][`LMCD_CMD_FLAG_BIT] == 1'b1)
			&& (f.data[0][6:0] == op)
			&& lmcd_for_us(f.data[1], addr);
	endfunction : lmcd_cmd_hit

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic therm_s1_q;
	logic therm_s2_q;
	logic therm_d_q;
	logic pin_s1_q;
	logic pin_s2_q;
	logic bemf_s1_q;
	logic bemf_s2_q;
	lmcd_pkg::lmcd_state_t state_q;
	lmcd_pkg::lmcd_state_t state_d;
	logic sleep_pending_q;
	logic sleep_pending_d;
	logic decel_q;
	logic sleep_q;
	logic bemf_route_q;
	logic [15:0] goal_q;
	lmcd_pkg::lmcd_params_t params_q;
	logic move_start_q;
	logic reject_q;
	logic level_q;
	logic pin_out_q;
	logic [5:0] frame_id;
	logic id_ok;
	logic fill_ok;
	logic is_move;
	logic is_sleep;
	logic is_stop;
	logic is_observe;
	logic good_frame;
	logic therm_rise;
	logic stop_req;
	logic move_ok;
	logic sleep_fb;
	logic sleep_reload;

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************

	// Brings the thermal flag, end-stop pin and integrator level into the clock domain.
	// Only the second stage of each chain is read, so a first stage that goes
	// metastable on an asynchronous edge never reaches the decode logic.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			therm_s1_q <= 1'b0;
			therm_s2_q <= 1'b0;
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			bemf_s1_q <= 1'b0;
			bemf_s2_q <= 1'b0;
		end else begin
			therm_s1_q <= thermal_shutdown_i;
			therm_s2_q <= therm_s1_q;
			pin_s1_q <= end_stop_pin_i;
			pin_s2_q <= pin_s1_q;
			bemf_s1_q <= bemf_integrator_i;
			bemf_s2_q <= bemf_s1_q;
		end
	end

	// Delays the synchronised thermal flag for edge detection.
	// It resets low, the idle level of the flag, so no false stop follows reset.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			therm_d_q <= 1'b0;
		end else begin
			therm_d_q <= therm_s2_q;
		end
	end

	// ****************************************************************
	// Frame decoding
	// ****************************************************************

	// Checks identifier parity and the fixed content of the sleep frame.
	// The checksum verdict itself comes from the link layer with the frame.
	always_comb begin
		frame_id = frame_i.ident[5:0];
		id_ok = (frame_i.ident[7:6] == lmcd_parity(frame_id)) && frame_i.cksum_ok;
		fill_ok = 1'b1;
		for (int i = 1; i < 8; i++) begin
			if (frame_i.data[i] != `LMCD_SLEEP_FILL) begin
				fill_ok = 1'b0;
			end
		end
	end

	// Classifies a well-formed frame; anything else is discarded untouched.
	always_comb begin
		is_move = (frame_id == move_ident_i)
			&& (frame_i.ident[`LMCD_ID_TYPE_BIT] == 1'b0)
			&& (frame_i.len == `LMCD_MOVE_LEN);
		is_sleep = (frame_id == `LMCD_SLEEP_ID)
			&& (frame_i.len == `LMCD_SLEEP_LEN)
			&& (frame_i.data[0] == `LMCD_SLEEP_FIRST)
			&& fill_ok;
		is_stop = lmcd_cmd_hit(frame_i, cmd_ident_i, node_address_i,
			`LMCD_OP_STOP);
		is_observe = lmcd_cmd_hit(frame_i, cmd_ident_i, node_address_i,
			`LMCD_OP_OBSERVE);
		good_frame = frame_valid_i && id_ok;
	end

	// Gathers the stop requests from the master and from thermal shutdown.
	// A stop is only acted on while the motor moves; an idle motor has nothing to stop.
	always_comb begin
		therm_rise = therm_s2_q && !therm_d_q;
		stop_req = ((good_frame && is_stop) || therm_rise)
			&& motion_busy_i
			&& !two_stage_motion_i;
		move_ok = good_frame && is_move && (state_q == lmcd_pkg::LMCD_RUN);
		sleep_fb = (fallback_position_i != `LMCD_FALLBACK_NONE);
		sleep_reload = (state_q == lmcd_pkg::LMCD_RUN) && good_frame && is_sleep
			&& motion_busy_i && sleep_fb;
	end

	// ****************************************************************
	// Command state machine
	// ****************************************************************

	// Works out the next command state from frames, stop requests and motor status.
	// A sleep that arrives during a stop is remembered, so the node still sleeps once
	// the motor has halted and the stop position has been kept.
	always_comb begin
		state_d = state_q;
		sleep_pending_d = sleep_pending_q;
		unique case (state_q)
			lmcd_pkg::LMCD_RUN: begin
				if (good_frame && is_sleep) begin
					if (motion_busy_i && !sleep_fb) begin
						state_d = lmcd_pkg::LMCD_STOPPING;
						sleep_pending_d = 1'b1;
					end else begin
						state_d = lmcd_pkg::LMCD_ASLEEP;
					end
				end else if (stop_req) begin
					state_d = lmcd_pkg::LMCD_STOPPING;
				end
			end
			lmcd_pkg::LMCD_STOPPING: begin
				if (!motion_busy_i) begin
					sleep_pending_d = 1'b0;
					if (sleep_pending_q || (good_frame && is_sleep)) begin
						state_d = lmcd_pkg::LMCD_ASLEEP;
					end else begin
						state_d = lmcd_pkg::LMCD_RUN;
					end
				end else if (good_frame && is_sleep) begin
					sleep_pending_d = 1'b1;
				end
			end
			lmcd_pkg::LMCD_ASLEEP: begin
				if (wake_i) begin
					state_d = lmcd_pkg::LMCD_RUN;
				end
			end
			default: begin
				// The fourth code of the state word is unused; fall back to running.
				state_d = lmcd_pkg::LMCD_RUN;
				sleep_pending_d = 1'b0;
			end
		endcase
	end

	// Holds the state and its output flags; the flags copy the next state so that the
	// stop and sleep outputs come straight from flip-flops with no decode behind them.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= lmcd_pkg::LMCD_RUN;
			sleep_pending_q <= 1'b0;
			decel_q <= 1'b0;
			sleep_q <= 1'b0;
		end else begin
			state_q <= state_d;
			sleep_pending_q <= sleep_pending_d;
			decel_q <= (state_d == lmcd_pkg::LMCD_STOPPING);
			sleep_q <= (state_d == lmcd_pkg::LMCD_ASLEEP);
		end
	end

	// ****************************************************************
	// Goal position and motion parameters
	// ****************************************************************

	// Updates the goal from moves, the fallback on sleep, or the stop position.
	// The three causes cannot meet in one cycle: moves and sleep reloads need the run
	// state, and the stop position is only taken while a stop is in progress.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			goal_q <= `LMCD_GOAL_RST;
		end else if (move_ok) begin
			goal_q <= {frame_i.data[0], frame_i.data[1]};
		end else if (sleep_reload) begin
			goal_q <= {{5{fallback_position_i[10]}}, fallback_position_i};
		end else if ((state_q == lmcd_pkg::LMCD_STOPPING) && !motion_busy_i) begin
			goal_q <= current_position_i;
		end
	end

	// Loads velocities, stall threshold and ramp rate from a move frame.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			params_q.vmax <= `LMCD_NIB_RST;
			params_q.vmin <= `LMCD_NIB_RST;
			params_q.stall_threshold <= `LMCD_NIB_RST;
			params_q.ramp_rate <= `LMCD_NIB_RST;
		end else if (move_ok) begin
			params_q.vmax <= frame_i.data[2][`LMCD_HI_NIB];
			params_q.vmin <= frame_i.data[2][`LMCD_LO_NIB];
			params_q.stall_threshold <= frame_i.data[3][`LMCD_HI_NIB];
			params_q.ramp_rate <= frame_i.data[3][`LMCD_LO_NIB];
		end
	end

	// Pulses move start for accepted moves and flags discarded frames.
	// A frame that is refused only by the current state is not flagged as bad.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			move_start_q <= 1'b0;
			reject_q <= 1'b0;
		end else begin
			move_start_q <= move_ok;
			reject_q <= frame_valid_i && !(id_ok
				&& (is_move || is_sleep || is_stop || is_observe));
		end
	end

	// ****************************************************************
	// Back-EMF observation and end-stop pin
	// ****************************************************************

	// Latches observation mode; only reset can clear it.
	// No command clears it, so a stray frame cannot hand the pin back to the switch.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bemf_route_q <= 1'b0;
		end else if (good_frame && is_observe) begin
			bemf_route_q <= 1'b1;
		end
	end

	// Drives the integrator level onto the pin while observing.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pin_out_q <= 1'b0;
		end else begin
			pin_out_q <= bemf_route_q && bemf_s2_q;
		end
	end

	// Samples the end-stop pin only while observation is off.
	// While the pin carries the integrator, its level says nothing about the switch.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			level_q <= 1'b0;
		end else if (!bemf_route_q) begin
			level_q <= pin_s2_q;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************

	// All outputs come straight from flip-flops.
	assign goal_position_o = goal_q;
	assign params_o = params_q;
	assign move_start_o = move_start_q;
	assign decel_stop_o = decel_q;
	assign sleep_o = sleep_q;
	assign cmd_reject_o = reject_q;
	assign end_stop_pin_o = pin_out_q;
	assign end_stop_pin_oe_o = bemf_route_q;
	assign end_stop_level_o = level_q;

endmodule : lmcd_decoder

/* File: testbench/lmcd_lin_master.sv */
// LIN master model that hands received command frames to the decoder.
`timescale 1ns/100ps
module lmcd_lin_master (
	// Clock.
	input wire logic sys_clk_i,
	// Frame towards the decoder.
	output logic frame_valid_o,
	output lmcd_pkg::lmcd_frame_t frame_o
);
	// ****
	// Frame source
	// ****
	// The lines start quiet at time zero.
	initial begin
		frame_valid_o = 1'b0;
		frame_o = '0;
	end
	// Protected identifier: two parity bits above the six identifier bits.
	function automatic logic [1:0] prot(input logic [5:0] id);
		if (id == 6'h3c) begin
			return 2'b00;
		end
		return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4]};
	endfunction : prot
	// One frame per call with a ready-made identifier byte; afterwards the lines are
	// inverted so nothing stale looks valid.
	task automatic send_pid(input logic [7:0] pid, input logic [63:0] d, input logic [3:0] n,
		input logic ok);
		@(posedge sys_clk_i);
		frame_valid_o <= 1'b1;
		frame_o <= {pid, d, n, ok};
		@(posedge sys_clk_i);
		frame_valid_o <= 1'b0;
		frame_o <= ~frame_o;
		#1;
	endtask : send_pid
	// One frame per call, its identifier protected by the proper parity bits.
	task automatic send(input logic [5:0] id, input logic [63:0] d, input logic [3:0] n,
		input logic ok);
		send_pid({prot(id), id}, d, n, ok);
	endtask : send
endmodule : lmcd_lin_master

/* File: testbench/lmcd_chk.sv */
// Concurrent checks on the ports of the motion command decoder.
`timescale 1ns/100ps
module lmcd_chk (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// Watched inputs.
	input wire logic frame_valid_i,
	input wire lmcd_pkg::lmcd_frame_t frame_i,
	input wire logic motion_busy_i,
	input wire logic wake_i,
	input wire logic [15:0] current_position_i,
	// Watched outputs.
	input wire logic [15:0] goal_position_o,
	input wire lmcd_pkg::lmcd_params_t params_o,
	input wire logic move_start_o,
	input wire logic decel_stop_o,
	input wire logic sleep_o,
	input wire logic cmd_reject_o,
	input wire logic end_stop_pin_o,
	input wire logic end_stop_pin_oe_o,
	input wire logic end_stop_level_o
);
	// All checks use the system clock and rest during reset.
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!resetn_i);
	// ****
	// Checks
	// ****
	move_goal_a: assert property (move_start_o |->
		goal_position_o == $past({frame_i.data[0], frame_i.data[1]})) else $error("bad goal");
	move_params_a: assert property (move_start_o |->
		params_o == $past({frame_i.data[2], frame_i.data[3]})) else $error("bad params");
	reject_cause_a: assert property (cmd_reject_o |->
		$past(frame_valid_i) && !move_start_o) else $error("reject without frame");
	stop_hold_a: assert property (decel_stop_o && !motion_busy_i |=>
		!decel_stop_o && goal_position_o == $past(current_position_i)) else $error("stop end");
	stop_idle_a: assert property (!motion_busy_i && !decel_stop_o |=>
		!decel_stop_o) else $error("stop while idle");
	sleep_hold_a: assert property (sleep_o && !wake_i |=> sleep_o)
		else $error("sleep left without wake");
	oe_hold_a: assert property (end_stop_pin_oe_o |=> end_stop_pin_oe_o)
		else $error("observe routing dropped");
	pin_quiet_a: assert property (!end_stop_pin_oe_o |-> !end_stop_pin_o)
		else $error("pin driven while not observing");
	level_frozen_a: assert property (end_stop_pin_oe_o && $past(end_stop_pin_oe_o) |->
		$stable(end_stop_level_o)) else $error("pin sampled while observing");
endmodule : lmcd_chk

bind lmcd_decoder lmcd_chk i_chk (
	.sys_clk_i(sys_clk_i),
	.resetn_i(resetn_i),
	.frame_valid_i(frame_valid_i),
	.frame_i(frame_i),
	.motion_busy_i(motion_busy_i),
	.wake_i(wake_i),
	.current_position_i(current_position_i),
	.goal_position_o(goal_position_o),
	.params_o(params_o),
	.move_start_o(move_start_o),
	.decel_stop_o(decel_stop_o),
	.sleep_o(sleep_o),
	.cmd_reject_o(cmd_reject_o),
	.end_stop_pin_o(end_stop_pin_o),
	.end_stop_pin_oe_o(end_stop_pin_oe_o),
	.end_stop_level_o(end_stop_level_o)
);

/* File: testbench/lin_motion_command_decoder_tb.sv */
// Self-checking bench for the motion command decoder.
`timescale 1ns/100ps
module lin_motion_command_decoder_tb;
	// ****
	// Signals
	// ****
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic fv;
	logic busy = 1'b0, two = 1'b0, wake = 1'b0, hot = 1'b0, pin_in = 1'b0, bemf = 1'b0;
	logic [15:0] cur = 16'h1234;
	logic [10:0] fb = 11'h5a3;
	logic [15:0] goal;
	logic ms, ds, slp, rej, pin, oe, lvl;
	lmcd_pkg::lmcd_frame_t frm;
	lmcd_pkg::lmcd_params_t prm;
	int n_fail = 0;
	int comparisons = 0;
	// The 40 MHz system clock.
	always #12.5 clk = ~clk;
	// Master model and decoder.
	lmcd_lin_master i_master (.sys_clk_i(clk), .frame_valid_o(fv), .frame_o(frm));
	lmcd_decoder i_dut (.sys_clk_i(clk), .resetn_i(rst_n), .frame_valid_i(fv), .frame_i(frm),
		.node_address_i(7'h15), .move_ident_i(6'h12), .cmd_ident_i(6'h0b),
		.motion_busy_i(busy), .two_stage_motion_i(two), .current_position_i(cur),
		.fallback_position_i(fb), .wake_i(wake), .thermal_shutdown_i(hot),
		.end_stop_pin_i(pin_in), .bemf_integrator_i(bemf), .goal_position_o(goal),
		.params_o(prm), .move_start_o(ms), .decel_stop_o(ds), .sleep_o(slp),
		.cmd_reject_o(rej), .end_stop_pin_o(pin), .end_stop_pin_oe_o(oe),
		.end_stop_level_o(lvl));
	// ****
	// Helpers
	// ****
	// Sign extension of the fallback into the goal.
	function automatic logic [15:0] sext(input logic [10:0] f);
		return {{5{f[10]}}, f};
	endfunction : sext
	// Compares and counts.
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check
	// Prints the counts and the verdict, then ends the run.
	task automatic summarize();
		$display("compared %0d, failed %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize
	// Lets edges pass and then the updates settle.
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	// Bounded wait on the stop indication.
	task automatic wait_ds(input logic want);
		for (int k = 0; k < 20 && ds !== want; k++) tick(1);
		check(ds, want);
		if (ds !== want) summarize();
	endtask : wait_ds
	// ****
	// Tests
	// ****
	// Main sequence.
	initial begin
		logic [15:0] v;
		logic [7:0] p;
		int i;
		void'($urandom(32'hc75c));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 12; i++) begin
			v = (i == 0) ? 16'h8000 : (i == 1) ? 16'h7fff : 16'($urandom);
			p = 8'($urandom);
			i_master.send(6'h12, {32'h0, p, ~p, v[7:0], v[15:8]}, 4'h4, 1'b1);
			check(ms, 1'b1);
			check(goal, v);
			check(prm, {~p, p});
		end
		i_master.send(6'h12, 64'h0, 4'h4, 1'b0);
		check(rej, 1'b1);
		i_master.send(6'h32, 64'h0, 4'h4, 1'b1);
		check(rej, 1'b1);
		// Identifier 0x12 with its two parity bits swapped.
		i_master.send_pid(8'h52, {32'h0, 32'h5566_7788}, 4'h4, 1'b1);
		check(rej, 1'b1);
		check(ms, 1'b0);
		check(goal, v);
		$display("test moves done");
		@(posedge clk);
		busy <= 1'b1;
		i_master.send(6'h0b, {48'h0, 8'h94, 8'h8f}, 4'h2, 1'b1);
		check(ds, 1'b0);
		@(posedge clk);
		two <= 1'b1;
		i_master.send(6'h0b, {48'h0, 8'h14, 8'h8f}, 4'h2, 1'b1);
		check(ds, 1'b0);
		@(posedge clk);
		two <= 1'b0;
		cur <= 16'($urandom);
		i_master.send(6'h0b, {48'h0, 8'h14, 8'h8f}, 4'h2, 1'b1);
		check(ds, 1'b1);
		@(posedge clk);
		busy <= 1'b0;
		wait_ds(1'b0);
		check(goal, cur);
		@(posedge clk);
		busy <= 1'b1;
		hot <= 1'b1;
		wait_ds(1'b1);
		@(posedge clk);
		busy <= 1'b0;
		hot <= 1'b0;
		wait_ds(1'b0);
		$display("test stops done");
		for (i = 0; i < 2; i++) begin
			@(posedge clk);
			busy <= 1'b1;
			fb <= i ? 11'h400 : 11'h5a3;
			i_master.send(6'h3c, {{7{8'hff}}, 8'h00}, 4'h8, 1'b1);
			if (i == 0) check(goal, sext(fb));
			else check(ds, 1'b1);
			@(posedge clk);
			busy <= 1'b0;
			wait_ds(1'b0);
			tick(1);
			check(slp, 1'b1);
			i_master.send(6'h12, 64'h0, 4'h4, 1'b1);
			check(goal, i ? cur : sext(fb));
			@(posedge clk);
			wake <= 1'b1;
			tick(2);
			check(slp, 1'b0);
			@(posedge clk);
			wake <= 1'b0;
		end
		i_master.send(6'h3c, {8'hfe, {6{8'hff}}, 8'h00}, 4'h8, 1'b1);
		check(rej, 1'b1);
		check(slp, 1'b0);
		i_master.send(6'h3c, {{7{8'hff}}, 8'h00}, 4'h8, 1'b1);
		check(slp, 1'b1);
		check(ds, 1'b0);
		@(posedge clk);
		wake <= 1'b1;
		tick(2);
		check(slp, 1'b0);
		@(posedge clk);
		wake <= 1'b0;
		$display("test sleep done");
		@(posedge clk);
		pin_in <= 1'b1;
		tick(4);
		check(lvl, 1'b1);
		i_master.send(6'h0b, {48'h0, 8'h6a, 8'h9f}, 4'h2, 1'b1);
		check(oe, 1'b1);
		for (i = 0; i < 8; i++) begin
			@(posedge clk);
			bemf <= 1'($urandom);
			pin_in <= 1'($urandom);
			tick(4);
			check(pin, bemf);
			check(lvl, 1'b1);
		end
		@(posedge clk);
		rst_n <= 1'b0;
		tick(2);
		check(oe, 1'b0);
		@(posedge clk);
		rst_n <= 1'b1;
		tick(2);
		check(oe, 1'b0);
		$display("test observe done");
		summarize();
	end
endmodule : lin_motion_command_decoder_tb
